// >>> inc/duty_msg_pkg.sv
// Constants, field layouts and frame carriers for the duty cycle message block.
// Assumes a 32-bit serial command frame, most significant bit first.
package duty_msg_pkg;

	// ---------------------------------------------
	// Sizes and codes
	// ---------------------------------------------
	localparam int          NUM_CH       = 8;
	localparam int          CH_W         = 3;
	localparam int          DUTY_W       = 19;
	localparam int          READ_W       = 21;
	localparam int          N_W          = 14;
	localparam int          M_W          = 10;
	localparam int          CNT_W        = 24;
	localparam logic [3:0]  MSG_DUTY     = 4'h8;
	localparam logic [5:0]  FRAME_BITS   = 6'h20;
	localparam logic [5:0]  BITS_MAX     = 6'h3F;
	localparam logic [4:0]  DIRECT_SCALE = 5'h00;   // Appended zeros give N times 32
	localparam logic [18:0] DUTY_RESET   = 19'h00000;
	localparam logic [20:0] READ_MASK    = 21'h1FE7FF; // Clears bits 12 and 11

	// ---------------------------------------------
	// Frame carriers
	// ---------------------------------------------
	typedef struct packed {
		logic              rw;
		logic [3:0]        message_identifier;
		logic [CH_W-1:0]   output_selector;
		logic [4:0]        unused;
		logic [DUTY_W-1:0] duty;
	} cmd_frame_t;

	typedef struct packed {
		logic              zero;
		logic [3:0]        message_identifier;
		logic [CH_W-1:0]   output_selector;
		logic [2:0]        pad;
		logic [READ_W-1:0] duty;
	} reply_frame_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SHIFT = 3'b010,
		ST_DONE  = 3'b100
	} link_state_t;

endpackage

// >>> rtl/duty_msg.sv
// Duty cycle message handler with per-channel PWM outputs.
// Assumes a mode-0 serial host; sclk, cs_n and mosi are asynchronous pins.
// Mode, period factors and regulator duty come from logic on clk.
`timescale 1ns/1ps
`default_nettype none

module duty_msg (
	// Clock and reset
	input  wire logic                                            clk,
	input  wire logic                                            rst,
	// Serial link pins
	input  wire logic                                            sclk,
	input  wire logic                                            cs_n,
	input  wire logic                                            mosi,
	output logic                                                 miso,
	output logic                                                 miso_oe_n,
	// Channel configuration
	input  wire logic [duty_msg_pkg::NUM_CH-1:0]                 direct_mode,
	input  wire logic [duty_msg_pkg::N_W-1:0]                    period_n,
	input  wire logic [duty_msg_pkg::M_W-1:0]                    period_m,
	input  wire logic [duty_msg_pkg::NUM_CH-1:0][duty_msg_pkg::READ_W-1:0] regulator_duty,
	// Channel outputs
	output logic [duty_msg_pkg::NUM_CH-1:0]                      pwm_out
);

	// ---------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------
	logic [2:0] sclk_q_r;
	logic [2:0] cs_q_r;
	logic [1:0] mosi_q_r;

	// Stage one feeds stage two only; stage three gives edge history
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_q_r <= 3'h0;
			cs_q_r   <= 3'h7;
			mosi_q_r <= 2'h0;
		end else begin
			sclk_q_r <= {sclk_q_r[1:0], sclk};
			cs_q_r   <= {cs_q_r[1:0], cs_n};
			mosi_q_r <= {mosi_q_r[0], mosi};
		end
	end

	logic sclk_rise;
	logic sclk_fall;
	logic sel;
	assign sclk_rise = sclk_q_r[1] & ~sclk_q_r[2];
	assign sclk_fall = ~sclk_q_r[1] & sclk_q_r[2];
	assign sel       = ~cs_q_r[1];

	// ---------------------------------------------
	// Frame engine and duty storage
	// ---------------------------------------------
	duty_msg_pkg::link_state_t                        state_r, state_nxt;
	logic [5:0]                                       bits_r, bits_nxt;
	logic [31:0]                                      rx_r, rx_nxt;
	logic [31:0]                                      tx_r, tx_nxt;
	logic                                             miso_r, miso_nxt;
	logic                                             oe_n_r, oe_n_nxt;
	logic [duty_msg_pkg::NUM_CH-1:0][duty_msg_pkg::DUTY_W-1:0] duty_r, duty_nxt;

	duty_msg_pkg::cmd_frame_t                         cmd;
	duty_msg_pkg::reply_frame_t                       rep;
	logic [duty_msg_pkg::DUTY_W-1:0]                  stored;

	// Next values of the frame engine
	always_comb begin
		state_nxt = state_r;
		bits_nxt  = bits_r;
		rx_nxt    = rx_r;
		tx_nxt    = tx_r;
		miso_nxt  = miso_r;
		oe_n_nxt  = oe_n_r;
		duty_nxt  = duty_r;
		cmd       = duty_msg_pkg::cmd_frame_t'(rx_r);
		rep       = '0;
		stored    = duty_r[cmd.output_selector];
		case (state_r)
			duty_msg_pkg::ST_IDLE: begin
				oe_n_nxt = 1'b1;
				if (sel) begin
					state_nxt = duty_msg_pkg::ST_SHIFT;
					bits_nxt  = 6'h00;
					miso_nxt  = tx_r[31];
					oe_n_nxt  = 1'b0;
				end
			end
			duty_msg_pkg::ST_SHIFT: begin
				if (!sel) begin
					oe_n_nxt = 1'b1;
					if (bits_r == duty_msg_pkg::FRAME_BITS) begin
						state_nxt = duty_msg_pkg::ST_DONE;
					end else begin
						state_nxt = duty_msg_pkg::ST_IDLE;
						tx_nxt    = 32'h00000000; // Broken frame: next reply is empty
					end
				end else if (sclk_rise) begin
					rx_nxt = {rx_r[30:0], mosi_q_r[1]};
					if (bits_r != duty_msg_pkg::BITS_MAX) begin
						bits_nxt = bits_r + 6'h01;
					end
				end else if (sclk_fall) begin
					tx_nxt   = {tx_r[30:0], 1'b0};
					miso_nxt = tx_r[30];
				end
			end
			duty_msg_pkg::ST_DONE: begin
				state_nxt = duty_msg_pkg::ST_IDLE;
				tx_nxt    = 32'h00000000;
				if (cmd.message_identifier == duty_msg_pkg::MSG_DUTY) begin
					if (cmd.rw) begin
						// Stored in either mode; only direct mode uses it
						duty_nxt[cmd.output_selector] = cmd.duty;
						stored = cmd.duty;
					end
					rep.zero               = 1'b0;
					rep.message_identifier = cmd.message_identifier;
					rep.output_selector    = cmd.output_selector;
					rep.pad                = 3'h0;
					if (direct_mode[cmd.output_selector]) begin
						rep.duty = {2'h0, stored} & duty_msg_pkg::READ_MASK;
					end else begin
						rep.duty = regulator_duty[cmd.output_selector];
					end
					tx_nxt = rep;
				end
			end
			default: begin
				state_nxt = duty_msg_pkg::ST_IDLE;
			end
		endcase
	end

	// Frame engine registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= duty_msg_pkg::ST_IDLE;
			bits_r  <= 6'h00;
			rx_r    <= 32'h00000000;
			tx_r    <= 32'h00000000;
			miso_r  <= 1'b0;
			oe_n_r  <= 1'b1;
			duty_r  <= {duty_msg_pkg::NUM_CH{duty_msg_pkg::DUTY_RESET}};
		end else begin
			state_r <= state_nxt;
			bits_r  <= bits_nxt;
			rx_r    <= rx_nxt;
			tx_r    <= tx_nxt;
			miso_r  <= miso_nxt;
			oe_n_r  <= oe_n_nxt;
			duty_r  <= duty_nxt;
		end
	end

	assign miso      = miso_r;
	assign miso_oe_n = oe_n_r;

	// ---------------------------------------------
	// PWM period counters and outputs
	// ---------------------------------------------
	// Wraps to zero at limit minus one; a zero limit holds at zero
	function automatic logic [duty_msg_pkg::CNT_W-1:0] next_count(
		input logic [duty_msg_pkg::CNT_W-1:0] cnt,
		input logic [duty_msg_pkg::CNT_W-1:0] limit
	);
		logic [duty_msg_pkg::CNT_W:0] inc;
		inc = {1'b0, cnt} + 25'h0000001;
		if (inc >= {1'b0, limit}) begin
			next_count = '0;
		end else begin
			next_count = inc[duty_msg_pkg::CNT_W-1:0];
		end
	endfunction

	logic [duty_msg_pkg::CNT_W-1:0] lim_direct;
	logic [duty_msg_pkg::CNT_W-1:0] lim_reg;
	logic [duty_msg_pkg::CNT_W-1:0] cnt_direct_r, cnt_direct_nxt;
	logic [duty_msg_pkg::CNT_W-1:0] cnt_reg_r, cnt_reg_nxt;
	logic [duty_msg_pkg::NUM_CH-1:0] pwm_r, pwm_nxt;

	assign lim_direct = {5'h00, period_n, duty_msg_pkg::DIRECT_SCALE};
	assign lim_reg    = period_n * period_m;

	// Duty compares above the running count; a nonzero duty at or past the limit stays on
	always_comb begin
		cnt_direct_nxt = next_count(cnt_direct_r, lim_direct);
		cnt_reg_nxt    = next_count(cnt_reg_r, lim_reg);
		for (int c = 0; c < duty_msg_pkg::NUM_CH; c++) begin
			if (direct_mode[c]) begin
				pwm_nxt[c] = {5'h00, duty_r[c]} > cnt_direct_r;
			end else begin
				pwm_nxt[c] = {3'h0, regulator_duty[c]} > cnt_reg_r;
			end
		end
	end

	// PWM registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_direct_r <= '0;
			cnt_reg_r    <= '0;
			pwm_r        <= '0;
		end else begin
			cnt_direct_r <= cnt_direct_nxt;
			cnt_reg_r    <= cnt_reg_nxt;
			pwm_r        <= pwm_nxt;
		end
	end

	assign pwm_out = pwm_r;

	// ---------------------------------------------
	// Assertions
	// ---------------------------------------------
	sequence s_duty_done;
		state_r == duty_msg_pkg::ST_DONE && rx_r[30:27] == duty_msg_pkg::MSG_DUTY;
	endsequence

	sequence s_duty_write;
		s_duty_done ##0 rx_r[31];
	endsequence

	property p_write_store;
		@(posedge clk) disable iff (rst)
		s_duty_write |=> duty_r[$past(rx_r[26:24])] == $past(rx_r[18:0]);
	endproperty
	a_write_store: assert property (p_write_store) else $error("duty write not stored");

	property p_read_keep;
		@(posedge clk) disable iff (rst)
		state_r == duty_msg_pkg::ST_DONE && !rx_r[31] |=> duty_r == $past(duty_r);
	endproperty
	a_read_keep: assert property (p_read_keep) else $error("read altered duty");

	property p_other_id;
		@(posedge clk) disable iff (rst)
		state_r == duty_msg_pkg::ST_DONE && rx_r[30:27] != duty_msg_pkg::MSG_DUTY |=> tx_r == 32'h00000000 && duty_r == $past(duty_r);
	endproperty
	a_other_id: assert property (p_other_id) else $error("foreign identifier acted on");

	property p_reply_head;
		@(posedge clk) disable iff (rst)
		s_duty_done |=> tx_r[31] == 1'b0 && tx_r[30:24] == $past(rx_r[30:24]) && tx_r[23:21] == 3'h0;
	endproperty
	a_reply_head: assert property (p_reply_head) else $error("reply header wrong");

	property p_reply_direct;
		@(posedge clk) disable iff (rst)
		s_duty_done ##0 direct_mode[rx_r[26:24]] |=> tx_r[12:11] == 2'h0 && tx_r[20:19] == 2'h0
			&& tx_r[18:13] == duty_r[$past(rx_r[26:24])][18:13] && tx_r[10:0] == duty_r[$past(rx_r[26:24])][10:0];
	endproperty
	a_reply_direct: assert property (p_reply_direct) else $error("direct readback wrong");

	property p_reply_reg;
		@(posedge clk) disable iff (rst)
		s_duty_done ##0 !direct_mode[rx_r[26:24]] |=> tx_r[20:0] == $past(regulator_duty[rx_r[26:24]]);
	endproperty
	a_reply_reg: assert property (p_reply_reg) else $error("regulator readback wrong");

	// Saturation and regulator tracking, watched on every channel
	for (genvar c = 0; c < duty_msg_pkg::NUM_CH; c++) begin : g_output_selector_chk
		property p_full_on;
			@(posedge clk) disable iff (rst)
			direct_mode[c] && cnt_direct_r < lim_direct && {5'h00, duty_r[c]} >= lim_direct
				##1 direct_mode[c] && $stable(duty_r[c]) |-> pwm_r[c];
		endproperty
		a_full_on: assert property (p_full_on) else $error("direct duty not saturated on");

		property p_reg_follow;
			@(posedge clk) disable iff (rst)
			!direct_mode[c] |=> pwm_r[c] == ({3'h0, $past(regulator_duty[c])} > $past(cnt_reg_r));
		endproperty
		a_reg_follow: assert property (p_reg_follow) else $error("regulated output ignores regulator");
	end

	property p_direct_period;
		@(posedge clk) disable iff (rst)
		lim_direct != '0 && $stable(lim_direct) |-> cnt_direct_r < lim_direct;
	endproperty
	a_direct_period: assert property (p_direct_period) else $error("direct count beyond period");

endmodule // duty_msg

`default_nettype wire

// >>> tb/spi_host.sv
// Host model: issues 32-bit command frames in mode 0, msb first.
// Assumes the device syncs sclk and cs_n to its own clock.
`timescale 1ns/1ps
`default_nettype none

module spi_host (
	// Link pins
	output logic        sclk,
	output logic        cs_n,
	output logic        mosi,
	input  wire logic   miso,
	input  wire logic   miso_oe_n,
	// Reply handed to the bench
	output logic        rx_valid,
	output logic [31:0] rx_word
);
	// Pins idle at time zero
	initial begin
		sclk     = 1'b0;
		cs_n     = 1'b1;
		mosi     = 1'b0;
		rx_valid = 1'b0;
		rx_word  = 32'h00000000;
	end

	// Shift the first nb bits of a frame at 160 ns per bit; clock rests low between frames
	task automatic shift_bits(input logic [31:0] cmd, input int nb);
		cs_n = 1'b0;
		#80;
		for (int i = 31; i > 31 - nb; i--) begin
			mosi = cmd[i];
			#80;
			sclk       = 1'b1;
			rx_word[i] = (miso_oe_n === 1'b0) ? miso : 1'bx; // Undriven line never matches
			#80;
			sclk = 1'b0;
		end
		cs_n = 1'b1;
		mosi = ~mosi;                      // Released line shows no stale bit
	endtask

	// One whole frame; the reply word is handed to the bench
	task automatic xfer(input logic [31:0] cmd);
		shift_bits(cmd, 32);
		rx_valid = 1'b1;
		#1;
		rx_valid = 1'b0;
		#160;
	endtask

	// A frame cut short after nb bits; nothing is handed over
	task automatic cut(input logic [31:0] cmd, input int nb);
		shift_bits(cmd, nb);
		#160;
	endtask
endmodule // spi_host
`default_nettype wire

// >>> tb/test_pwm_duty_cycle_message.sv
// Testbench for the duty cycle message handler.
// Assumes replies arrive one frame late and N=2, M=4 for short periods.
`timescale 1ns/1ps
`default_nettype none

module test_pwm_duty_cycle_message;
	logic                                                    clk = 1'b0;
	logic                                                    rst = 1'b1;
	logic                                                    sclk, cs_n, mosi, miso, miso_oe_n, rx_valid;
	logic [31:0]                                             rx_word;
	logic [7:0]                                              direct_mode = 8'hDF;
	logic [13:0]                                             period_n = 14'h0002;
	logic [9:0]                                              period_m = 10'h004;
	logic [duty_msg_pkg::NUM_CH-1:0][duty_msg_pkg::READ_W-1:0] regulator_duty = '0;
	logic [7:0]                                              pwm_out;
	logic [31:0]                                             exp_q[$];
	int                                                      error_cnt = 0;
	int                                                      n_checks = 0;

	duty_msg i_duty_msg (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
		.miso_oe_n(miso_oe_n), .direct_mode(direct_mode), .period_n(period_n), .period_m(period_m),
		.regulator_duty(regulator_duty), .pwm_out(pwm_out));
	spi_host i_spi_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n),
		.rx_valid(rx_valid), .rx_word(rx_word));

	// Clock, 8 ns period
	always #4 clk = ~clk;

	// Compare and count
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, s);
		end
	endtask

	// Verdict and end of run
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Expected reply word for a duty message
	function automatic logic [31:0] rep(input logic [2:0] ch, input logic [20:0] d);
		duty_msg_pkg::reply_frame_t r;
		r                    = '0;
		r.message_identifier = 4'h8;
		r.output_selector    = ch;
		r.duty               = d;
		return r;
	endfunction

	// Direct mode readback clears bits 12 and 11
	function automatic logic [20:0] dm(input logic [18:0] d);
		return {2'b00, d & 19'h7E7FF};
	endfunction

	// Send one frame and note the reply it earns in the next frame
	task automatic frame(input logic rw, input logic [3:0] id, input logic [2:0] ch, input logic [18:0] d,
		input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge clk);
		#1;
		i_spi_host.xfer({rw, id, ch, 5'h00, d});
	endtask

	// Count high cycles of one channel over one period
	task automatic pwm(input int ch, input int p, input int e);
		int h;
		h = 0;
		repeat (2 * p) @(posedge clk);
		repeat (p) begin
			@(posedge clk);
			#1;
			if (pwm_out[ch] === 1'b1)
				h++;
		end
		chk("pwm high cycles", 32'(e), 32'(h));
	endtask

	// Reply monitor: oldest note against each reply seen
	always @(posedge rx_valid) begin
		if (exp_q.size() == 0)
			chk("reply count", 32'h00000001, 32'h00000000);
		else
			chk("reply", exp_q.pop_front(), rx_word);
	end

	// Watchdog
	initial begin
		#500us;
		error_cnt++;
		$display("watchdog expired");
		end_sim();
	end

	// Main sequence
	initial begin
		logic [18:0] d1, d2;
		d1 = 19'($urandom(32'h94a5)) | 19'h01800;
		d2 = 19'($urandom);
		for (int i = 0; i < 8; i++)
			regulator_duty[i] = 21'($urandom);
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (3) @(posedge clk);
		exp_q.push_back(32'h00000000);
		frame(1'b0, 4'h8, 3'h0, 19'h00000, rep(3'h0, 21'h000000));
		frame(1'b1, 4'h8, 3'h3, d1, rep(3'h3, dm(d1)));
		frame(1'b0, 4'h8, 3'h3, 19'($urandom), rep(3'h3, dm(d1)));
		frame(1'b1, 4'h8, 3'h5, d2, rep(3'h5, regulator_duty[5]));
		frame(1'b1, 4'h9, 3'h3, 19'h00000, 32'h00000000);
		$display("test readback done");
		@(posedge clk);
		#1;
		direct_mode = 8'hFF;
		frame(1'b0, 4'h8, 3'h5, 19'h00000, rep(3'h5, dm(d2)));
		frame(1'b0, 4'h8, 3'h3, 19'h00000, rep(3'h3, dm(d1)));
		// A cut frame hides the pending reply and earns an empty one
		exp_q[0] = 32'h00000000;
		@(posedge clk);
		#1;
		i_spi_host.cut({1'b1, 4'h8, 3'h3, 5'h00, 19'h00000}, 16);
		frame(1'b0, 4'h8, 3'h3, 19'h00000, rep(3'h3, dm(d1)));
		$display("test mode switch done");
		@(posedge clk);
		#1;
		direct_mode       = 8'hDF;
		regulator_duty[5] = 21'h000003;
		pwm(5, 8, 3);
		frame(1'b1, 4'h8, 3'h3, 19'h00014, rep(3'h3, dm(19'h00014)));
		pwm(3, 64, 20);
		frame(1'b1, 4'h8, 3'h3, 19'h7FFFF, rep(3'h3, dm(19'h7FFFF)));
		pwm(3, 64, 64);
		@(posedge clk);
		#1;
		i_spi_host.xfer(32'h00000000);
		chk("notes left", 32'h00000000, 32'(exp_q.size()));
		$display("test pwm done");
		end_sim();
	end
endmodule // test_pwm_duty_cycle_message
`default_nettype wire
